// ===== bench/backplane_model.sv
// backplane model: far-side drivers and line termination
`timescale 1ns/1ps
`default_nettype none
module backplane_model (
  input wire logic [1:0] dev_bit_i,
  input wire logic [1:0] dev_bit_oe_i,
  input wire logic [1:0] far_bit_i,
  input wire logic [1:0] far_bit_en_i,
  input wire logic [7:0] dev_byte_i,
  input wire logic dev_byte_oe_i,
  input wire logic [7:0] far_byte_i,
  input wire logic far_byte_en_i,
  output logic [1:0] bit_o,
  output logic [7:0] byte_o
);
  // terminated lines float high when nobody drives them
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (dev_bit_oe_i[i]) bit_o[i] = dev_bit_i[i];
      else bit_o[i] = far_bit_en_i[i] ? far_bit_i[i] : 1'h1;
    end
    if (dev_byte_oe_i) byte_o = dev_byte_i;
    else byte_o = far_byte_en_i ? far_byte_i : 8'hff;
  end
endmodule
`default_nettype wire

// ===== bench/ubt_properties.sv
// port checker for the universal bus transceiver
`timescale 1ns/1ps
`default_nettype none
module ubt_properties #(
  parameter int WIDE_W = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [universal_bus_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic wide_outputs_off_n_i,
  input wire logic flow_sense_i,
  input wire logic pass_through_ctrl_i,
  input wire logic a_to_b_store_clk_i,
  input wire logic [1:0] a_to_b_drive_on_i,
  input wire logic [1:0] y_feedback_on_n_i,
  input wire logic [1:0] single_bit_input_i,
  input wire logic [1:0] backplane_bit_o,
  input wire logic [1:0] backplane_bit_oe_o,
  input wire logic [1:0] monitor_out_oe_o,
  input wire logic [WIDE_W-1:0] wide_card_side_i,
  input wire logic [WIDE_W-1:0] wide_backplane_side_o,
  input wire logic wide_card_side_oe_o,
  input wire logic wide_backplane_side_oe_o
);
  // pins cross two sync flops and an output flop: only judge outputs
  // once the pins have been quiet long enough to reach them
  logic [WIDE_W+9:0] pins;
  logic [WIDE_W+9:0] pins_q;
  logic [2:0] calm_q;
  logic calm;
  logic soft_q;
  assign pins = {wide_outputs_off_n_i, flow_sense_i, pass_through_ctrl_i,
    a_to_b_store_clk_i, a_to_b_drive_on_i, y_feedback_on_n_i,
    single_bit_input_i, wide_card_side_i};
  assign calm = calm_q > 3'h3;
  // register-driven controls replace the pins, so pin checks rest then
  always_ff @(posedge mclk_i) begin
    if (reset_i) soft_q <= 1'h0;
    else if (psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0]
        && paddr_i == universal_bus_pkg::CTRL_OFS)
      soft_q <= pwdata_i[universal_bus_pkg::CTRL_SOFT_BIT];
  end
  always_ff @(posedge mclk_i) begin
    pins_q <= pins;
    if (reset_i || soft_q || pins != pins_q) calm_q <= 3'h0;
    else if (calm_q != 3'h7) calm_q <= calm_q + 3'h1;
  end
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  AST_BIT_OE: assert property (
    calm |-> backplane_bit_oe_o == $past(a_to_b_drive_on_i))
    else $error("bit drive enable wrong");
  AST_BIT_DATA: assert property (
    calm |-> (backplane_bit_o & backplane_bit_oe_o)
      == ($past(single_bit_input_i) & backplane_bit_oe_o))
    else $error("bit drive data wrong");
  AST_MON_OE: assert property (
    calm |-> monitor_out_oe_o == ~$past(y_feedback_on_n_i))
    else $error("monitor enable wrong");
  AST_WIDE_OFF: assert property (
    calm && $past(wide_outputs_off_n_i)
      |-> !wide_card_side_oe_o && !wide_backplane_side_oe_o)
    else $error("wide side driven while off");
  AST_WIDE_DIR: assert property (
    calm && !$past(wide_outputs_off_n_i)
      |-> wide_backplane_side_oe_o == $past(flow_sense_i)
        && wide_card_side_oe_o != $past(flow_sense_i))
    else $error("wide direction wrong");
  AST_PASS: assert property (
    calm && $past(pass_through_ctrl_i) && wide_backplane_side_oe_o
      |-> wide_backplane_side_o == $past(wide_card_side_i))
    else $error("transparent path wrong");
  AST_HOLD: assert property (
    calm && !$past(pass_through_ctrl_i) |=> $stable(wide_backplane_side_o))
    else $error("stored byte moved");
  AST_READY_WAIT: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule
bind universal_bus_transceiver ubt_properties #(.WIDE_W(WIDE_W)) i_props (.*);
`default_nettype wire

// ===== bench/universal_bus_transceiver_test.sv
// self-checking bench for the universal bus transceiver
`timescale 1ns/1ps
`default_nettype none
module universal_bus_transceiver_test;
  logic mclk_i = 1'h0, reset_i = 1'h1, err;
  logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hf;
  logic wide_outputs_off_n_i = 1'h1, flow_sense_i = 1'h0;
  logic pass_through_ctrl_i = 1'h0;
  logic a_to_b_store_clk_i = 1'h0, b_to_a_store_clk_i = 1'h0;
  logic [1:0] a_to_b_drive_on_i = 2'h0, y_feedback_on_n_i = 2'h3;
  logic [1:0] single_bit_input_i = 2'h0, far_bit = 2'h0;
  logic [1:0] monitor_out_o, monitor_out_oe_o, backplane_bit_i;
  logic [1:0] backplane_bit_o, backplane_bit_oe_o;
  logic [7:0] wide_card_side_i, wide_card_side_o;
  logic [7:0] wide_backplane_side_i, wide_backplane_side_o;
  logic [7:0] card_drv = 8'h00, far_byte = 8'h00;
  logic pready_o, pslverr_o, capture_log_ready_o;
  logic wide_card_side_oe_o, wide_backplane_side_oe_o;
  int n_fail = 0, tests_run = 0, cyc = 0;

  universal_bus_transceiver i_dut (.*);
  backplane_model i_far (
    .dev_bit_i(backplane_bit_o),
    .dev_bit_oe_i(backplane_bit_oe_o),
    .far_bit_i(far_bit),
    .far_bit_en_i(~a_to_b_drive_on_i),
    .dev_byte_i(wide_backplane_side_o),
    .dev_byte_oe_i(wide_backplane_side_oe_o),
    .far_byte_i(far_byte),
    .far_byte_en_i(~flow_sense_i),
    .bit_o(backplane_bit_i),
    .byte_o(wide_backplane_side_i)
  );
  // card logic lets go of its byte whenever the device drives it
  assign wide_card_side_i = wide_card_side_oe_o ? wide_card_side_o : card_drv;

  always #2.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      results();
    end
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'h1;
    // values read here are those from before this edge's updates
    do @(posedge mclk_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge mclk_i);
  endtask
  // eight edges cover sync, output flop and the monitor round trip
  task automatic settle;
    repeat (8) @(posedge mclk_i);
  endtask
  task automatic src(input int d, input logic [7:0] x);
    if (d) far_byte <= x;
    else card_drv <= x;
  endtask
  task automatic sclk(input int d, input logic l);
    if (d) b_to_a_store_clk_i <= l;
    else a_to_b_store_clk_i <= l;
  endtask
  function automatic logic [7:0] dst(input int d);
    return d ? wide_card_side_o : wide_backplane_side_o;
  endfunction

  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'h0;
    settle();
    apb(1'h0, universal_bus_pkg::CTRL_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0194);
    apb(1'h1, universal_bus_pkg::CTRL_OFS, 32'h0000_0190);
    apb(1'h1, universal_bus_pkg::PINS_OFS, 32'h0000_ffff);
    apb(1'h0, universal_bus_pkg::CTRL_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0190);
    apb(1'h0, universal_bus_pkg::PINS_OFS, 32'h0000_0000);
    check(rd, 32'h0000_010c);
    apb(1'h0, 12'h010, 32'h0000_0000);
    check(err, 1'h1);
    check(rd, 32'h0000_0000);
    $display("registers done");
    for (int m = 0; m < 16; m++) begin
      a_to_b_drive_on_i <= m[1:0];
      y_feedback_on_n_i <= m[3:2];
      single_bit_input_i <= m[2:1];
      far_bit <= ~m[2:1];
      settle();
      check(backplane_bit_oe_o, m[1:0]);
      check(backplane_bit_o & m[1:0], m[2:1] & m[1:0]);
      check(monitor_out_oe_o, 2'(~m[3:2]));
      check(monitor_out_o & 2'(~m[3:2]),
        2'(~(m[2:1] ^ m[1:0]) & ~m[3:2]));
    end
    $display("single-bit done");
    pass_through_ctrl_i <= 1'h1;
    card_drv <= 8'h5a;
    far_byte <= 8'hc3;
    for (int i = 0; i < 4; i++) begin
      wide_outputs_off_n_i <= i[1];
      flow_sense_i <= i[0];
      settle();
      check({wide_card_side_oe_o, wide_backplane_side_oe_o},
        {!i[1] && !i[0], !i[1] && i[0]});
      if (i == 1) check(wide_backplane_side_o, 8'h5a);
      if (i == 0) check(wide_card_side_o, 8'hc3);
    end
    $display("wide done");
    for (int d = 0; d < 2; d++) begin
      flow_sense_i <= 1'(d == 0);
      wide_outputs_off_n_i <= 1'h0;
      pass_through_ctrl_i <= 1'h1;
      sclk(d, 1'h1);
      src(d, 8'ha5);
      settle();
      pass_through_ctrl_i <= 1'h0;
      settle();
      src(d, 8'h3c);
      settle();
      check(dst(d), 8'ha5);
      sclk(d, 1'h0);
      settle();
      check(dst(d), 8'ha5);
      sclk(d, 1'h1);
      settle();
      check(dst(d), 8'h3c);
      wide_outputs_off_n_i <= 1'h1;
      sclk(d, 1'h0);
      src(d, 8'h7e);
      settle();
      sclk(d, 1'h1);
      settle();
      check({wide_card_side_oe_o, wide_backplane_side_oe_o}, 2'h0);
      wide_outputs_off_n_i <= 1'h0;
      settle();
      check(dst(d), 8'h7e);
    end
    $display("storage done");
    flow_sense_i <= 1'h1;
    apb(1'h1, universal_bus_pkg::CTRL_OFS, 32'h0000_0002);
    for (int i = 0; i < 9; i++) begin
      a_to_b_store_clk_i <= 1'h0;
      card_drv <= 8'(8'h10 + i);
      settle();
      a_to_b_store_clk_i <= 1'h1;
      settle();
    end
    check(capture_log_ready_o, 1'h0);
    apb(1'h0, universal_bus_pkg::STATUS_OFS, 32'h0000_0000);
    check(rd[17:0], 18'h3_7e18);
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, universal_bus_pkg::LOG_OFS, 32'h0000_0000);
      check(rd[8:0], 9'h110 + i);
    end
    apb(1'h0, universal_bus_pkg::LOG_OFS, 32'h0000_0000);
    check(rd[8], 1'h0);
    check(capture_log_ready_o, 1'h1);
    $display("log done");
    apb(1'h1, universal_bus_pkg::CTRL_OFS, 32'h0000_0001);
    settle();
    check(backplane_bit_oe_o, 2'h0);
    check(monitor_out_oe_o, 2'h3);
    check(monitor_out_o, 2'h3);
    check({wide_card_side_oe_o, wide_backplane_side_oe_o}, 2'h2);
    check(wide_card_side_o, 8'h7e);
    pstrb_i <= 4'h2;
    apb(1'h1, universal_bus_pkg::CTRL_OFS, 32'h0000_01ff);
    pstrb_i <= 4'hf;
    apb(1'h0, universal_bus_pkg::CTRL_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0101);
    check(monitor_out_oe_o, 2'h1);
    apb(1'h1, universal_bus_pkg::CTRL_OFS, 32'h0000_0000);
    settle();
    check(backplane_bit_oe_o, 2'h3);
    $display("soft controls done");
    results();
  end
endmodule
`default_nettype wire

// ===== hdl/universal_bus_pkg.sv
// shared constants and carrier types for the universal bus transceiver
package universal_bus_pkg;

  localparam int WIDE_W = 8;
  localparam int LOG_DEPTH = 8;
  localparam int ADDR_W = 12;
  localparam int CTRL_W = 9;

  // register byte addresses on the apb side
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] PINS_OFS = 12'h008;
  localparam logic [11:0] LOG_OFS = 12'h00c;

  // control register fields
  localparam int CTRL_SOFT_BIT = 0;
  localparam int CTRL_LOG_BIT = 1;
  localparam int CTRL_OFF_N_BIT = 2;
  localparam int CTRL_FLOW_BIT = 3;
  localparam int CTRL_PASS_BIT = 4;
  localparam int CTRL_DRIVE_LSB = 5;
  localparam int CTRL_FB_N_LSB = 7;
  // soft controls start in isolation: wide off, bits off, monitors off
  localparam logic [8:0] CTRL_RESET = 9'h194;

  // status register fields
  localparam int STAT_AB_LSB = 0;
  localparam int STAT_BA_LSB = 8;
  localparam int STAT_LOG_VALID_BIT = 16;
  localparam int STAT_LOG_FULL_BIT = 17;

  // log register fields
  localparam int LOG_VALID_BIT = 8;

  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic wide_outputs_off_n;
    logic flow_sense;
    logic pass_through_ctrl;
    logic [1:0] a_to_b_drive_on;
    logic [1:0] y_feedback_on_n;
    logic a_to_b_store_clk;
    logic b_to_a_store_clk;
  } ctrl_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [WIDE_W-1:0] wide_card_side;
    logic [WIDE_W-1:0] wide_backplane_side;
    logic [1:0] single_bit_input;
    logic [1:0] backplane_bit;
  } pins_t;

  typedef struct packed {
    logic [1:0] bit_out;
    logic [1:0] bit_oe;
    logic [1:0] mon_out;
    logic [1:0] mon_oe;
    logic [WIDE_W-1:0] card_out;
    logic card_oe;
    logic [WIDE_W-1:0] bp_out;
    logic bp_oe;
  } drive_t;

endpackage

// ===== hdl/universal_bus_transceiver.sv
// universal bus transceiver core, capture log fifo and apb register slave
// How it works
// R1: every path carries its source level unchanged, no inversion anywhere.
// R2: bit drive enable high drives the backplane bit from its card input.
// R3: bit drive enable low releases the backplane bit.
// R4: feedback enable low drives the monitor output from the backplane bit.
// R5: feedback enable high releases the monitor output.
// R6: both enables active: drive backplane and monitor it together.
// R7: outside logic may tie both bit enables into one direction line.
// R8: wide enable low drives whichever wide side is the destination.
// R9: wide enable high releases both wide sides whatever else is set.
// R10: flow sense high sends card to backplane, low backplane to card.
// R11: pass-through high makes the wide path follow its source.
// R12: pass-through low with steady store clock holds the stored byte.
// R13: pass-through low, store clock rising edge captures the source byte.
// R14: backplane-to-card path works the same with its own store clock.
// R15: clock high as pass-through falls keeps the level before the fall.
// R16: clock low with pass-through low keeps the earlier output level.
// R17: storage keeps working while outputs are disabled.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module capture_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  // depth must be a power of two so the pointers wrap on their own
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st_q;
  fifo_state_t st_d;
  logic push;
  logic pop;

  // a push while full is refused; the writer must watch in_ready_o
  assign in_ready_o = (st_q.count != FULL_COUNT);
  assign out_valid_o = (st_q.count != '0);
  assign out_data_o = st_q.mem[st_q.rd];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data_i;
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: st_d.count = st_q.count + 1'b1;
      2'b01: st_d.count = st_q.count - 1'b1;
      default: st_d.count = st_q.count;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module universal_bus_transceiver #(
  parameter int WIDE_W = universal_bus_pkg::WIDE_W,
  parameter int LOG_DEPTH = universal_bus_pkg::LOG_DEPTH
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [universal_bus_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // control pins
  input wire logic wide_outputs_off_n_i,
  input wire logic flow_sense_i,
  input wire logic pass_through_ctrl_i,
  input wire logic a_to_b_store_clk_i,
  input wire logic b_to_a_store_clk_i,
  input wire logic [1:0] a_to_b_drive_on_i,
  input wire logic [1:0] y_feedback_on_n_i,
  // single-bit transceivers, index 0 is channel one, index 1 channel two
  input wire logic [1:0] single_bit_input_i,
  output logic [1:0] monitor_out_o,
  output logic [1:0] monitor_out_oe_o,
  input wire logic [1:0] backplane_bit_i,
  output logic [1:0] backplane_bit_o,
  output logic [1:0] backplane_bit_oe_o,
  // eight-bit path
  input wire logic [WIDE_W-1:0] wide_card_side_i,
  output logic [WIDE_W-1:0] wide_card_side_o,
  output logic wide_card_side_oe_o,
  input wire logic [WIDE_W-1:0] wide_backplane_side_i,
  output logic [WIDE_W-1:0] wide_backplane_side_o,
  output logic wide_backplane_side_oe_o,
  // capture log back-pressure: low means a clocked capture is not logged
  output logic capture_log_ready_o
);

  typedef struct packed {
    universal_bus_pkg::pins_t sync1;
    universal_bus_pkg::pins_t sync2;
    logic ab_clk_prev;
    logic ba_clk_prev;
    logic [WIDE_W-1:0] ab_store;
    logic [WIDE_W-1:0] ba_store;
    universal_bus_pkg::drive_t drv;
    logic [universal_bus_pkg::CTRL_W-1:0] ctrl_reg;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;
  universal_bus_pkg::pins_t pins_now;
  universal_bus_pkg::ctrl_t eff;
  logic ab_rise;
  logic ba_rise;
  logic log_push;
  logic log_ready;
  logic log_valid;
  logic log_pop;
  logic [WIDE_W-1:0] log_data;
  logic [WIDE_W-1:0] log_byte;
  logic apb_access;
  logic apb_done;

  // one storage element per direction: latch when transparent, else
  // edge-stored; a steady clock leaves the byte as it was
  function automatic logic [WIDE_W-1:0] store_next(
    input logic pass,
    input logic rise,
    input logic [WIDE_W-1:0] src,
    input logic [WIDE_W-1:0] held
  );
    logic [WIDE_W-1:0] r;
    r = held; // R12 R15 R16
    if (pass) begin
      r = src; // R11
    end else if (rise) begin
      r = src; // R13
    end
    return r;
  endfunction

  // soft mode replaces the level controls, the store clocks stay on pins
  function automatic universal_bus_pkg::ctrl_t pick_ctrl(
    input logic [universal_bus_pkg::CTRL_W-1:0] creg,
    input universal_bus_pkg::ctrl_t pin
  );
    universal_bus_pkg::ctrl_t c;
    c = pin;
    if (creg[universal_bus_pkg::CTRL_SOFT_BIT]) begin
      c.wide_outputs_off_n = creg[universal_bus_pkg::CTRL_OFF_N_BIT];
      c.flow_sense = creg[universal_bus_pkg::CTRL_FLOW_BIT];
      c.pass_through_ctrl = creg[universal_bus_pkg::CTRL_PASS_BIT];
      c.a_to_b_drive_on = creg[universal_bus_pkg::CTRL_DRIVE_LSB +: 2];
      c.y_feedback_on_n = creg[universal_bus_pkg::CTRL_FB_N_LSB +: 2];
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin gathering and effective controls

  always_comb begin
    pins_now.ctrl.wide_outputs_off_n = wide_outputs_off_n_i;
    pins_now.ctrl.flow_sense = flow_sense_i;
    pins_now.ctrl.pass_through_ctrl = pass_through_ctrl_i;
    pins_now.ctrl.a_to_b_drive_on = a_to_b_drive_on_i;
    pins_now.ctrl.y_feedback_on_n = y_feedback_on_n_i;
    pins_now.ctrl.a_to_b_store_clk = a_to_b_store_clk_i;
    pins_now.ctrl.b_to_a_store_clk = b_to_a_store_clk_i;
    pins_now.wide_card_side = wide_card_side_i;
    pins_now.wide_backplane_side = wide_backplane_side_i;
    pins_now.single_bit_input = single_bit_input_i;
    pins_now.backplane_bit = backplane_bit_i;
  end

  assign eff = pick_ctrl(st_q.ctrl_reg, st_q.sync2.ctrl);
  // edges come from the second synchroniser stage only
  // a store clock held high through reset counts as one rising edge
  assign ab_rise = eff.a_to_b_store_clk & ~st_q.ab_clk_prev; // R13
  assign ba_rise = eff.b_to_a_store_clk & ~st_q.ba_clk_prev; // R14

  // only clocked captures of the card-to-backplane path are logged
  assign log_push = ~eff.pass_through_ctrl & ab_rise &
                    st_q.ctrl_reg[universal_bus_pkg::CTRL_LOG_BIT];
  assign capture_log_ready_o = log_ready;

  ////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state, answer from flops

  assign apb_access = psel_i & penable_i;
  assign apb_done = apb_access & st_q.ready;
  // the log pops only as the read completes, never on the wait state
  assign log_pop = apb_done & ~pwrite_i &
                   (paddr_i == universal_bus_pkg::LOG_OFS);

  capture_fifo #(
    .WIDTH(WIDE_W),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(log_push),
    .in_ready_o(log_ready),
    .in_data_i(log_byte),
    .out_valid_o(log_valid),
    .out_ready_i(log_pop),
    .out_data_o(log_data)
  );

  // byte the log records: the source that the edge is capturing
  assign log_byte = st_q.sync2.wide_card_side;

  function automatic logic [31:0] read_word(
    input logic [universal_bus_pkg::ADDR_W-1:0] addr,
    input top_state_t s,
    input logic lv,
    input logic lr,
    input logic [WIDE_W-1:0] ld
  );
    logic [31:0] w;
    w = universal_bus_pkg::RDATA_ZERO;
    case (addr)
      universal_bus_pkg::CTRL_OFS: begin
        w[universal_bus_pkg::CTRL_W-1:0] = s.ctrl_reg;
      end
      universal_bus_pkg::STATUS_OFS: begin
        w[universal_bus_pkg::STAT_AB_LSB +: WIDE_W] = s.ab_store;
        w[universal_bus_pkg::STAT_BA_LSB +: WIDE_W] = s.ba_store;
        w[universal_bus_pkg::STAT_LOG_VALID_BIT] = lv;
        w[universal_bus_pkg::STAT_LOG_FULL_BIT] = ~lr;
      end
      universal_bus_pkg::PINS_OFS: begin
        w[universal_bus_pkg::CTRL_W-1:0] = s.sync2.ctrl;
      end
      universal_bus_pkg::LOG_OFS: begin
        w[WIDE_W-1:0] = lv ? ld : '0;
        w[universal_bus_pkg::LOG_VALID_BIT] = lv;
      end
      default: begin
        w = universal_bus_pkg::RDATA_ZERO;
      end
    endcase
    return w;
  endfunction

  function automatic logic addr_known(
    input logic [universal_bus_pkg::ADDR_W-1:0] addr
  );
    return (addr == universal_bus_pkg::CTRL_OFS) ||
           (addr == universal_bus_pkg::STATUS_OFS) ||
           (addr == universal_bus_pkg::PINS_OFS) ||
           (addr == universal_bus_pkg::LOG_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;

    // two-flop synchroniser for every pin input
    st_d.sync1 = pins_now;
    st_d.sync2 = st_q.sync1;
    st_d.ab_clk_prev = eff.a_to_b_store_clk;
    st_d.ba_clk_prev = eff.b_to_a_store_clk;

    // storage runs whatever the output enables are doing
    st_d.ab_store = store_next(eff.pass_through_ctrl, ab_rise,
                               st_q.sync2.wide_card_side,
                               st_q.ab_store); // R17
    st_d.ba_store = store_next(eff.pass_through_ctrl, ba_rise,
                               st_q.sync2.wide_backplane_side,
                               st_q.ba_store); // R14 R17

    // single-bit transceivers, straight through with no inversion
    st_d.drv.bit_out = st_q.sync2.single_bit_input; // R1 R2
    st_d.drv.bit_oe = eff.a_to_b_drive_on; // R2 R3
    // the monitor watches the pin itself, so with both enables active it
    // reflects our own drive as seen on the wire
    st_d.drv.mon_out = st_q.sync2.backplane_bit; // R4 R6
    st_d.drv.mon_oe = ~eff.y_feedback_on_n; // R4 R5

    // eight-bit drivers: enable picks nothing or the destination side
    st_d.drv.bp_out = st_d.ab_store; // R1
    st_d.drv.card_out = st_d.ba_store; // R1
    st_d.drv.bp_oe = ~eff.wide_outputs_off_n & eff.flow_sense; // R8 R9 R10
    st_d.drv.card_oe = ~eff.wide_outputs_off_n & ~eff.flow_sense; // R8 R10

    // apb: take the access, answer one cycle later
    st_d.ready = apb_access & ~st_q.ready;
    if (apb_access & ~st_q.ready) begin
      st_d.rdata = pwrite_i ? universal_bus_pkg::RDATA_ZERO :
                   read_word(paddr_i, st_q, log_valid, log_ready, log_data);
      // unmapped words answer with an error; read-only ones drop writes
      st_d.slverr = ~addr_known(paddr_i);
    end
    if (apb_done & pwrite_i & (paddr_i == universal_bus_pkg::CTRL_OFS)) begin
      if (pstrb_i[0]) begin
        st_d.ctrl_reg[7:0] = pwdata_i[7:0];
      end
      if (pstrb_i[1]) begin
        st_d.ctrl_reg[8] = pwdata_i[8];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= '0;
      st_q.ctrl_reg <= universal_bus_pkg::CTRL_RESET;
      // sync stages wake at the released levels, so no driver turns on
      // before the real pin levels reach the second stage
      st_q.sync1.ctrl.wide_outputs_off_n <= 1'b1;
      st_q.sync2.ctrl.wide_outputs_off_n <= 1'b1;
      st_q.sync1.ctrl.y_feedback_on_n <= 2'b11;
      st_q.sync2.ctrl.y_feedback_on_n <= 2'b11;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_o = st_q.rdata;
  assign pready_o = st_q.ready;
  assign pslverr_o = st_q.ready & st_q.slverr;
  assign backplane_bit_o = st_q.drv.bit_out;
  assign backplane_bit_oe_o = st_q.drv.bit_oe;
  assign monitor_out_o = st_q.drv.mon_out;
  assign monitor_out_oe_o = st_q.drv.mon_oe;
  assign wide_backplane_side_o = st_q.drv.bp_out;
  assign wide_backplane_side_oe_o = st_q.drv.bp_oe;
  assign wide_card_side_o = st_q.drv.card_out;
  assign wide_card_side_oe_o = st_q.drv.card_oe;

endmodule

`default_nettype wire
